/* File: hdl/slc_top.sv */
// slip buffer and loopback code interrupt registers with APB slave
//
// Contract
// - full enable bit 2 gates full interrupt
// - write to full buffer with no read in the same cycle deletes a frame
// - read from empty buffer repeats a frame
// - empty enable bit 1 gates empty interrupt
// - slip enable bit 0 gates either slip
// - slip enables read/write, reset to zero
// - status bit 3 shows activation code present
// - status bit 2 shows deactivation code present
// - bit 1 sets on activation state change
// - bit 0 sets on deactivation state change
// - change flags clear on status read
// - bits 7-4 reserved, defined bits reset zero
// - detectors compare against programmable code registers
// - loop code enables bit 1 and 0
// - slip status bit 0, plus empty/full bits
`timescale 1ns/1ps
`default_nettype none
module slc_top #(
  parameter logic [3:0] CHAN        = slc_pkg::CHAN_DEF,
  parameter int         FRAME_BYTES = slc_pkg::FRAME_BYTES,
  parameter int         DET_MATCHES = slc_pkg::DET_MATCHES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_wr_en,
  input  wire logic [7:0]  rx_wr_data,
  input  wire logic        rx_rd_en,
  output logic      [7:0]  rx_rd_data,
  input  wire logic        rx_smp_vld,
  input  wire logic [7:0]  rx_smp,
  output logic             act_code_present,
  output logic             deact_code_present,
  output logic             irq
);
  import slc_pkg::*;

  slc_top_state_t st_ff, nxt_st;
  slc_slip_evt_t  slip_evt;
  slc_det_t       act_det;
  slc_det_t       deact_det;

  // receive slip buffer
  slc_slip_buf #(
    .DW    (8),
    .FRAME (FRAME_BYTES),
    .DEPTH (FRAME_BYTES * FRAMES)
  ) u_slip (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (rx_wr_en),
    .wr_data (rx_wr_data),
    .rd_en   (rx_rd_en),
    .rd_data (rx_rd_data),
    .evt     (slip_evt)
  );

  // activation code detector
  slc_code_det #(
    .DW      (8),
    .MATCHES (DET_MATCHES)
  ) u_act (
    .pclk    (pclk),
    .presetn (presetn),
    .det_en  (st_ff.det_en[1]),
    .code    (st_ff.act_code),
    .smp_vld (rx_smp_vld),
    .smp     (rx_smp),
    .det     (act_det)
  );

  // deactivation code detector
  slc_code_det #(
    .DW      (8),
    .MATCHES (DET_MATCHES)
  ) u_deact (
    .pclk    (pclk),
    .presetn (presetn),
    .det_en  (st_ff.det_en[0]),
    .code    (st_ff.deact_code),
    .smp_vld (rx_smp_vld),
    .smp     (rx_smp),
    .det     (deact_det)
  );

  // address decode helpers
  logic        access;
  logic        done;
  logic        chan_hit;
  logic [11:0] idx;
  logic        wr_done;
  logic        rd_done;
  logic        wr_byte;

  assign access   = psel && penable;
  assign done     = access && st_ff.pready;
  assign idx      = paddr[13:2];
  assign chan_hit = (paddr[31:18] == '0) && (paddr[17:14] == CHAN) && (paddr[1:0] == 2'h0);
  assign wr_done  = done && pwrite && chan_hit && !st_ff.pslverr;
  assign rd_done  = done && !pwrite && chan_hit && !st_ff.pslverr;
  assign wr_byte  = wr_done && pstrb[0];

  // loop code status byte as read by software
  logic [7:0] lc_status;
  always_comb begin
    lc_status = REG_RST;
    lc_status[ACT_STATE_BIT]   = act_det.present;
    lc_status[DEACT_STATE_BIT] = deact_det.present;
    lc_status[ACT_CHG_BIT]     = st_ff.lc_chg[1];
    lc_status[DEACT_CHG_BIT]   = st_ff.lc_chg[0];
  end

  // read mux and mapped check
  logic [7:0] rd_byte;
  logic       mapped;
  always_comb begin
    rd_byte = REG_RST;
    mapped  = 1'b1;
    if (!chan_hit) begin
      mapped = 1'b0;
    end else if (idx == IDX_SLIP_STATUS) begin
      rd_byte = {5'h00, st_ff.slip_sts};
    end else if (idx == IDX_SLIP_EN) begin
      rd_byte = {5'h00, st_ff.slip_en};
    end else if (idx == IDX_LC_STATUS) begin
      rd_byte = lc_status;
    end else if (idx == IDX_LC_EN) begin
      rd_byte = {6'h00, st_ff.lc_en};
    end else if (idx == IDX_ACT_CODE) begin
      rd_byte = st_ff.act_code;
    end else if (idx == IDX_DEACT_CODE) begin
      rd_byte = st_ff.deact_code;
    end else if (idx == IDX_DET_CTRL) begin
      rd_byte = {6'h00, st_ff.det_en};
    end else begin
      mapped = 1'b0;
    end
  end

  // next state: bus answer, register writes, sticky flags, interrupt
  always_comb begin
    logic [2:0] slip_set;
    logic [1:0] lc_set;
    slip_set = SLIP_RST;
    lc_set   = LC_RST;
    nxt_st   = st_ff;
    // one wait state, answer on the second access cycle
    nxt_st.pready = access && !st_ff.pready;
    if (access && !st_ff.pready) begin
      nxt_st.pslverr = !mapped;
      nxt_st.prdata  = pwrite ? RDATA_RST : {24'h000000, rd_byte};
    end else if (!access) begin
      nxt_st.pslverr = 1'b0;
    end
    // control registers
    if (wr_byte) begin
      if (idx == IDX_SLIP_EN) begin
        nxt_st.slip_en = pwdata[2:0];
      end else if (idx == IDX_LC_EN) begin
        nxt_st.lc_en = pwdata[1:0];
      end else if (idx == IDX_ACT_CODE) begin
        nxt_st.act_code = pwdata[7:0];
      end else if (idx == IDX_DEACT_CODE) begin
        nxt_st.deact_code = pwdata[7:0];
      end else if (idx == IDX_DET_CTRL) begin
        nxt_st.det_en = pwdata[1:0];
      end
    end
    // status clears: reset on read, or write one to clear
    if (rd_done && (idx == IDX_SLIP_STATUS)) begin
      nxt_st.slip_sts = SLIP_RST;
    end else if (wr_byte && (idx == IDX_SLIP_STATUS)) begin
      nxt_st.slip_sts = st_ff.slip_sts & ~pwdata[2:0];
    end
    if (rd_done && (idx == IDX_LC_STATUS)) begin
      nxt_st.lc_chg = LC_RST;
    end else if (wr_byte && (idx == IDX_LC_STATUS)) begin
      nxt_st.lc_chg = st_ff.lc_chg & ~pwdata[1:0];
    end
    // events set after the clear so that a set wins
    slip_set[SLIP_FULL_BIT]  = slip_evt.full;
    slip_set[SLIP_EMPTY_BIT] = slip_evt.empty;
    slip_set[SLIP_EVT_BIT]   = slip_evt.full || slip_evt.empty;
    lc_set[1] = act_det.change;
    lc_set[0] = deact_det.change;
    nxt_st.slip_sts = nxt_st.slip_sts | slip_set;
    nxt_st.lc_chg   = nxt_st.lc_chg | lc_set;
    // level interrupt from unmasked sticky bits
    nxt_st.irq = |(nxt_st.slip_sts & nxt_st.slip_en) || |(nxt_st.lc_chg & nxt_st.lc_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign prdata             = st_ff.prdata;
  assign pready             = st_ff.pready;
  assign pslverr            = st_ff.pslverr;
  assign irq                = st_ff.irq;
  assign act_code_present   = act_det.present;
  assign deact_code_present = deact_det.present;

  property p_full_irq;
    @(posedge pclk) disable iff (!presetn)
    (slip_evt.full && st_ff.slip_en[2]) |-> ##1 (st_ff.slip_sts[2] && irq);
  endproperty
  a_full_irq: assert property (p_full_irq) else $error("full slip gave no interrupt");

  property p_empty_irq;
    @(posedge pclk) disable iff (!presetn)
    (slip_evt.empty && st_ff.slip_en[1]) |=> (st_ff.slip_sts[1] && irq);
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("empty slip gave no interrupt");

  property p_slip_flag;
    @(posedge pclk) disable iff (!presetn)
    (slip_evt.full || slip_evt.empty) |=> st_ff.slip_sts[0];
  endproperty
  a_slip_flag: assert property (p_slip_flag) else $error("slip flag not set");

  property p_slip_en_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_byte && (idx == IDX_SLIP_EN)) |=> (st_ff.slip_en == $past(pwdata[2:0]));
  endproperty
  a_slip_en_write: assert property (p_slip_en_write) else $error("slip enable not stored");

  property p_act_state_read;
    @(posedge pclk) disable iff (!presetn)
    (access && !pready && !pwrite && chan_hit && (idx == IDX_LC_STATUS))
      |=> (prdata[3] == $past(act_det.present)) && (prdata[2] == $past(deact_det.present));
  endproperty
  a_act_state_read: assert property (p_act_state_read) else $error("code state misread");

  property p_act_change;
    @(posedge pclk) disable iff (!presetn)
    act_det.change |=> st_ff.lc_chg[1];
  endproperty
  a_act_change: assert property (p_act_change) else $error("activation change lost");

  property p_deact_change;
    @(posedge pclk) disable iff (!presetn)
    deact_det.change |=> st_ff.lc_chg[0];
  endproperty
  a_deact_change: assert property (p_deact_change) else $error("deactivation change lost");

  property p_read_clears;
    @(posedge pclk) disable iff (!presetn)
    (rd_done && (idx == IDX_LC_STATUS) && !act_det.change && !deact_det.change)
      |=> (st_ff.lc_chg == 2'h0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear flags");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite) |-> (prdata[31:8] == 24'h000000) && ($past(idx) != IDX_LC_STATUS || prdata[7:4] == 4'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_lc_irq;
    @(posedge pclk) disable iff (!presetn)
    (act_det.change && st_ff.lc_en[1]) |=> irq;
  endproperty
  a_lc_irq: assert property (p_lc_irq) else $error("loop code change gave no interrupt");

  property p_irq_cause;
    @(posedge pclk) disable iff (!presetn)
    irq |-> (|(st_ff.slip_sts & st_ff.slip_en) || |(st_ff.lc_chg & st_ff.lc_en));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enabled flag");

  property p_answer_time;
    @(posedge pclk) disable iff (!presetn)
    (access && !pready) |=> pready ##1 !pready;
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("bus answer late");
endmodule
`default_nettype wire

/* File: inc/slc_pkg.sv */
// package: register map, field layout, carrier and state types for the slip/loop-code block
package slc_pkg;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 8;
  localparam int          FRAME_BYTES     = 24;
  localparam int          FRAMES          = 2;
  localparam int          DET_MATCHES     = 4;
  localparam logic [3:0]  CHAN_DEF        = 4'h0;
  // register indices; byte address is four times the index, channel nibble above
  localparam logic [11:0] IDX_SLIP_STATUS = 12'hB08;
  localparam logic [11:0] IDX_SLIP_EN     = 12'hB09;
  localparam logic [11:0] IDX_LC_STATUS   = 12'hB0A;
  localparam logic [11:0] IDX_LC_EN       = 12'hB0B;
  localparam logic [11:0] IDX_ACT_CODE    = 12'h126;
  localparam logic [11:0] IDX_DEACT_CODE  = 12'h127;
  localparam logic [11:0] IDX_DET_CTRL    = 12'h128;
  // slip status and enable layout
  localparam int          SLIP_EVT_BIT    = 0;
  localparam int          SLIP_EMPTY_BIT  = 1;
  localparam int          SLIP_FULL_BIT   = 2;
  // loop code status and enable layout
  localparam int          DEACT_CHG_BIT   = 0;
  localparam int          ACT_CHG_BIT     = 1;
  localparam int          DEACT_STATE_BIT = 2;
  localparam int          ACT_STATE_BIT   = 3;
  // reset values
  localparam logic [7:0]  REG_RST         = 8'h00;
  localparam logic [2:0]  SLIP_RST        = 3'h0;
  localparam logic [1:0]  LC_RST          = 2'h0;
  localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

  // slip events from the receive buffer
  typedef struct packed {
    logic full;
    logic empty;
  } slc_slip_evt_t;

  // one loop code detector output
  typedef struct packed {
    logic present;
    logic change;
  } slc_det_t;

  // top-level register state
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [2:0]  slip_en;
    logic [2:0]  slip_sts;
    logic [1:0]  lc_en;
    logic [1:0]  lc_chg;
    logic [7:0]  act_code;
    logic [7:0]  deact_code;
    logic [1:0]  det_en;
    logic        irq;
  } slc_top_state_t;
endpackage

/* File: hdl/slc_slip_buf.sv */
// receive slip buffer: two-frame elastic store with frame delete and repeat
`timescale 1ns/1ps
`default_nettype none
module slc_slip_buf #(
  parameter int DW    = 8,
  parameter int FRAME = 24,
  parameter int DEPTH = 48
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   wr_en,
  input  wire logic [DW-1:0]          wr_data,
  input  wire logic                   rd_en,
  output logic      [DW-1:0]          rd_data,
  output slc_pkg::slc_slip_evt_t      evt
);
  import slc_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW:0] DEP_L = (PW+1)'(DEPTH);
  localparam logic [PW:0] FRM_L = (PW+1)'(FRAME);

  typedef struct packed {
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [CW-1:0] cnt;
    logic [DW-1:0] rd_data;
    slc_slip_evt_t evt;
  } slc_sb_state_t;

  slc_sb_state_t st_ff, nxt_st;
  logic [DW-1:0] mem [DEPTH];

  // modular pointer add over a non power-of-two depth
  function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p, input logic [PW:0] k);
    logic [PW:0] s;
    s = {1'b0, p} + k;
    ptr_add = (s >= DEP_L) ? PW'(s - DEP_L) : PW'(s);
  endfunction

  logic full, empty;
  assign full  = (st_ff.cnt == CW'(DEPTH));
  assign empty = (st_ff.cnt == '0);

  // pointer, count and slip handling
  always_comb begin
    logic [CW-1:0] c;
    c = st_ff.cnt;
    nxt_st = st_ff;
    nxt_st.evt = '0;
    if (wr_en && full && !rd_en) begin
      nxt_st.rd_ptr = ptr_add(st_ff.rd_ptr, FRM_L);
      c = c - CW'(FRAME);
      nxt_st.evt.full = 1'b1;
    end
    if (rd_en && empty) begin
      nxt_st.rd_ptr = ptr_add(st_ff.rd_ptr, DEP_L - FRM_L);
      c = c + CW'(FRAME);
      nxt_st.evt.empty = 1'b1;
    end
    if (rd_en) begin
      nxt_st.rd_data = mem[nxt_st.rd_ptr];
      nxt_st.rd_ptr  = ptr_add(nxt_st.rd_ptr, (PW+1)'(1));
      c = c - CW'(1);
    end
    if (wr_en) begin
      nxt_st.wr_ptr = ptr_add(st_ff.wr_ptr, (PW+1)'(1));
      c = c + CW'(1);
    end
    nxt_st.cnt = c;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // storage, no reset needed
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[st_ff.wr_ptr] <= wr_data;
    end
  end

  assign rd_data = st_ff.rd_data;
  assign evt     = st_ff.evt;

  property p_full_delete;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && full && !rd_en) |=> (st_ff.cnt == CW'(DEPTH - FRAME + 1)) && evt.full;
  endproperty
  a_full_delete: assert property (p_full_delete) else $error("full write did not drop a frame");

  property p_empty_repeat;
    @(posedge pclk) disable iff (!presetn)
    (rd_en && empty && !wr_en) |=> (st_ff.cnt == CW'(FRAME - 1)) && evt.empty;
  endproperty
  a_empty_repeat: assert property (p_empty_repeat) else $error("empty read did not repeat a frame");
endmodule
`default_nettype wire

/* File: hdl/slc_code_det.sv */
// loopback code detector: run of matching samples against a programmed code
`timescale 1ns/1ps
`default_nettype none
module slc_code_det #(
  parameter int DW      = 8,
  parameter int MATCHES = 4
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              det_en,
  input  wire logic [DW-1:0]     code,
  input  wire logic              smp_vld,
  input  wire logic [DW-1:0]     smp,
  output slc_pkg::slc_det_t      det
);
  import slc_pkg::*;
  localparam int RW = $clog2(MATCHES + 1);

  typedef struct packed {
    logic [RW-1:0] run;
    slc_det_t      det;
  } slc_cd_state_t;

  slc_cd_state_t st_ff, nxt_st;

  // count matches, report presence and every change of it
  always_comb begin
    nxt_st = st_ff;
    if (!det_en) begin
      nxt_st.run = '0;
    end else if (smp_vld) begin
      if (smp == code) begin
        nxt_st.run = (st_ff.run == RW'(MATCHES)) ? st_ff.run : st_ff.run + RW'(1);
      end else begin
        nxt_st.run = '0;
      end
    end
    nxt_st.det.present = det_en && (nxt_st.run == RW'(MATCHES));
    nxt_st.det.change  = nxt_st.det.present != st_ff.det.present;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign det = st_ff.det;

  property p_present_needs_en;
    @(posedge pclk) disable iff (!presetn)
    !det_en |=> !det.present;
  endproperty
  a_present_needs_en: assert property (p_present_needs_en) else $error("code shown while disabled");
endmodule
`default_nettype wire

/* File: verif/tb_slc_top.sv */
// self-checking testbench for the slip and loop code interrupt register block
`timescale 1ns/1ps
`default_nettype none
module tb_slc_top;
  import slc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_wr_en = 1'b0;
  logic [7:0]  rx_wr_data = 8'h00;
  logic        rx_rd_en = 1'b0;
  logic [7:0]  rx_rd_data;
  logic        rx_smp_vld = 1'b0;
  logic [7:0]  rx_smp = 8'h00;
  logic        act_code_present;
  logic        deact_code_present;
  logic        irq;
  logic [31:0] rd_val;
  logic        err_val;
  logic [7:0]  byte_val;
  int          n_mismatch = 0;
  int          checks_done = 0;

  slc_top uut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .rx_wr_en           (rx_wr_en),
    .rx_wr_data         (rx_wr_data),
    .rx_rd_en           (rx_rd_en),
    .rx_rd_data         (rx_rd_data),
    .rx_smp_vld         (rx_smp_vld),
    .rx_smp             (rx_smp),
    .act_code_present   (act_code_present),
    .deact_code_present (deact_code_present),
    .irq                (irq)
  );

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, waits for pready; only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {18'h0, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    err_val = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd_val, exp);
  endtask

  // irq level once register updates have landed (detector disable needs three edges)
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // consecutive byte writes into the receive buffer
  task automatic wr_bytes(input logic [7:0] first, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_wr_en <= 1'b1;
      rx_wr_data <= first + 8'(i);
    end
    @(posedge pclk);
    rx_wr_en <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // single byte read, data taken the cycle after
  task automatic rd_byte();
    @(posedge pclk);
    rx_rd_en <= 1'b1;
    @(posedge pclk);
    rx_rd_en <= 1'b0;
    @(posedge pclk);
    byte_val = rx_rd_data;
  endtask

  task automatic send_smp(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_smp_vld <= 1'b1;
      rx_smp <= v;
    end
    @(posedge pclk);
    rx_smp_vld <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // reset values, read/write enables, unmapped index
  task automatic t_regs();
    rd(IDX_SLIP_EN, 32'h0000_0000);
    rd(IDX_LC_STATUS, 32'h0000_0000);
    rd(IDX_LC_EN, 32'h0000_0000);
    wr(IDX_SLIP_EN, 32'h0000_00FF);
    rd(IDX_SLIP_EN, 32'h0000_0007);
    wr(IDX_LC_EN, 32'h0000_00FF);
    rd(IDX_LC_EN, 32'h0000_0003);
    apb(1'b0, 12'h300, 32'h0000_0000);
    chk({31'h0, err_val}, 32'h0000_0001);
    wr(IDX_SLIP_EN, 32'h0000_0000);
    wr(IDX_LC_EN, 32'h0000_0000);
  endtask

  // overflow: frame deleted, full and slip flags, enable gating
  task automatic t_full();
    wr_bytes(8'h00, 48);
    rd(IDX_SLIP_STATUS, 32'h0000_0000);
    wr_bytes(8'h30, 1);
    irq_is(1'b0);
    wr(IDX_SLIP_EN, 32'h0000_0002);
    irq_is(1'b0);
    wr(IDX_SLIP_EN, 32'h0000_0004);
    irq_is(1'b1);
    rd(IDX_SLIP_STATUS, 32'h0000_0005);
    irq_is(1'b0);
    for (int i = 0; i < 25; i++) begin
      rd_byte();
      chk({24'h0, byte_val}, {24'h0, 8'h18 + 8'(i)});
    end
    rd(IDX_SLIP_STATUS, 32'h0000_0000);
  endtask

  // underflow: frame repeated, empty and slip flags, enable gating
  task automatic t_empty();
    rd_byte();
    chk({24'h0, byte_val}, 32'h0000_0019);
    irq_is(1'b0);
    wr(IDX_SLIP_EN, 32'h0000_0001);
    irq_is(1'b1);
    wr(IDX_SLIP_EN, 32'h0000_0002);
    irq_is(1'b1);
    rd(IDX_SLIP_STATUS, 32'h0000_0003);
    irq_is(1'b0);
    wr(IDX_SLIP_EN, 32'h0000_0000);
  endtask

  // loop code detection states and change flags
  task automatic t_loop();
    wr(IDX_ACT_CODE, 32'h0000_005A);
    wr(IDX_DEACT_CODE, 32'h0000_00C3);
    wr(IDX_LC_EN, 32'h0000_0002);
    wr(IDX_DET_CTRL, 32'h0000_0003);
    send_smp(8'h5A, 3);
    chk({31'h0, act_code_present}, 32'h0000_0000);
    send_smp(8'h5A, 1);
    chk({31'h0, act_code_present}, 32'h0000_0001);
    chk({31'h0, deact_code_present}, 32'h0000_0000);
    irq_is(1'b1);
    rd(IDX_LC_STATUS, 32'h0000_000A);
    rd(IDX_LC_STATUS, 32'h0000_0008);
    irq_is(1'b0);
    send_smp(8'h00, 1);
    rd(IDX_LC_STATUS, 32'h0000_0002);
    send_smp(8'hC3, 4);
    chk({31'h0, deact_code_present}, 32'h0000_0001);
    irq_is(1'b0);
    rd(IDX_LC_STATUS, 32'h0000_0005);
    wr(IDX_LC_EN, 32'h0000_0001);
    wr(IDX_DET_CTRL, 32'h0000_0000);
    irq_is(1'b1);
    chk({31'h0, deact_code_present}, 32'h0000_0000);
    rd(IDX_LC_STATUS, 32'h0000_0001);
  endtask

  // write strobe masking, write-one-to-clear, reset in mid-run
  task automatic t_misc();
    wr(IDX_DET_CTRL, 32'h0000_0001);
    send_smp(8'hC3, 4);
    irq_is(1'b1);
    wr(IDX_LC_STATUS, 32'h0000_0001);
    irq_is(1'b0);
    rd(IDX_LC_STATUS, 32'h0000_0004);
    pstrb <= 4'h0;
    wr(IDX_SLIP_EN, 32'h0000_0007);
    pstrb <= 4'hF;
    rd(IDX_SLIP_EN, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(IDX_LC_STATUS, 32'h0000_0000);
    rd(IDX_LC_EN, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // verdict and end of run
  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_full();
    t_empty();
    t_loop();
    t_misc();
    end_sim();
  end

  // hang guard
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
